/* core/ispb_bridge.sv */
// I2C slave bridge forwarding register accesses to sensor SPI
`include "ispb_regs.svh"
module ispb_bridge #(
   parameter logic [6:0] DEV_ADDR = `ISPB_DEV_ADDR,
   parameter logic [15:0] FW_VERSION = 16'h0102, // Arbitrary value
   parameter int STRETCH_CYC = `ISPB_STRETCH_US * `ISPB_CLK_MHZ,
   parameter logic [7:0] SPI_HALF = 8'h04
)(
   input wire logic i_core_clk, // System clock
   input wire logic i_sys_rst, // Async reset, high
   ispb_if.dev link, // I2C link
   input wire logic i_spi_miso, // Sensor SPI data in
   output logic o_spi_sclk, // Sensor SPI clock
   output logic o_spi_cs_n, // Sensor SPI select, low
   output logic o_spi_mosi, // Sensor SPI data out
   output logic o_page // Current page select
);
   ispb_pkg::ispb_dev_t s_q, s_d;

   // Local register decode
   function automatic logic is_local(input logic [7:0] a);
      is_local = (a == `ISPB_FW_VER_OFS) || (a == `ISPB_CTRL_OFS) ||
                 (a == `ISPB_STAT_OFS);
   endfunction

   // Sensor register number from page and address
   function automatic logic [8:0] map_reg(input logic p,
                                          input logic [7:0] a);
      map_reg = (p ? `ISPB_PAGE_SIZE : 9'h000) + {1'b0, a};
   endfunction

   // ==========================================================
   // Next state
   always_comb
   begin
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic [15:0] lv;
      rise = 1'b0;
      fall = 1'b0;
      start = 1'b0;
      stop = 1'b0;
      lv = 16'h0000;
      s_d = s_q;
      // Pin synchronisers
      s_d.scl_s = {s_q.scl_s[0], link.scl};
      s_d.sda_s = {s_q.sda_s[0], link.sda};
      s_d.miso_s = {s_q.miso_s[0], i_spi_miso};
      s_d.scl_l = s_q.scl_s[1];
      s_d.sda_l = s_q.sda_s[1];
      rise = s_q.scl_s[1] & ~s_q.scl_l;
      fall = ~s_q.scl_s[1] & s_q.scl_l;
      start = s_q.scl_s[1] & s_q.scl_l & s_q.sda_l & ~s_q.sda_s[1];
      stop = s_q.scl_s[1] & s_q.scl_l & ~s_q.sda_l & s_q.sda_s[1];
      // Local read value
      if (s_q.reg_a == `ISPB_FW_VER_OFS)
      begin
         lv = FW_VERSION;
      end
      else if (s_q.reg_a == `ISPB_CTRL_OFS)
      begin
         lv[`ISPB_PAGE_BIT] = s_q.page;
      end
      else
      begin
         lv[`ISPB_WBUSY_BIT] = s_q.wbusy;
         lv[`ISPB_RBUSY_BIT] = s_q.rbusy;
      end
      // SPI engine
      if (s_q.spi_act)
      begin
         if (s_q.spi_div == 8'h00)
         begin
            s_d.spi_div = SPI_HALF - 8'h01;
            if (!s_q.sclk)
            begin
               s_d.sclk = 1'b1;
               s_d.spi_rx = {s_q.spi_rx[14:0], s_q.miso_s[1]};
            end
            else
            begin
               s_d.sclk = 1'b0;
               if (s_q.spi_cnt == 5'h00)
               begin
                  s_d.spi_act = 1'b0;
                  s_d.cs_n = 1'b1;
                  s_d.wbusy = 1'b0;
               end
               else
               begin
                  s_d.spi_cnt = s_q.spi_cnt - 5'h01;
                  s_d.spi_sh = {s_q.spi_sh[24:0], 1'b0};
                  s_d.mosi = s_q.spi_sh[24];
               end
            end
         end
         else
         begin
            s_d.spi_div = s_q.spi_div - 8'h01;
         end
      end
      // I2C slave
      if (start)
      begin
         s_d.st = ispb_pkg::D_RX;
         s_d.bc = 4'h0;
         s_d.idx = 2'h0;
         s_d.sda_oe = 1'b0;
      end
      else if (stop)
      begin
         s_d.st = ispb_pkg::D_IDLE;
         s_d.sda_oe = 1'b0;
      end
      else
      begin
         case (s_q.st)
            ispb_pkg::D_RX:
            begin
               if (rise)
               begin
                  s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
                  s_d.bc = s_q.bc + 4'h1;
               end
               else if (fall && s_q.bc == 4'h8)
               begin
                  s_d.st = ispb_pkg::D_RACK;
                  s_d.sda_oe = 1'b1;
                  if (s_q.idx == 2'h0)
                  begin
                     s_d.rd = s_q.sh[0];
                     if (s_q.sh[7:1] != DEV_ADDR)
                     begin
                        s_d.st = ispb_pkg::D_IDLE;
                        s_d.sda_oe = 1'b0;
                     end
                  end
                  else if (s_q.idx == 2'h1)
                  begin
                     s_d.reg_a = s_q.sh;
                  end
                  else if (s_q.idx == 2'h2)
                  begin
                     s_d.hi = s_q.sh;
                  end
                  else if (s_q.reg_a == `ISPB_CTRL_OFS)
                  begin
                     s_d.page = s_q.sh[`ISPB_PAGE_BIT];
                  end
                  else if (!is_local(s_q.reg_a) && !s_q.spi_act)
                  begin
                     s_d.spi_act = 1'b1;
                     s_d.spi_sh = {map_reg(s_q.page, s_q.reg_a), 1'b1,
                                   s_q.hi, s_q.sh};
                     s_d.wbusy = 1'b1;
                  end
               end
            end
            ispb_pkg::D_RACK:
            begin
               if (fall)
               begin
                  s_d.sda_oe = 1'b0;
                  s_d.bc = 4'h0;
                  s_d.idx = s_q.idx + 2'h1;
                  s_d.st = ispb_pkg::D_RX;
                  if (s_q.idx == 2'h3)
                  begin
                     s_d.st = ispb_pkg::D_IDLE;
                  end
                  else if (s_q.rd && s_q.idx == 2'h0)
                  begin
                     s_d.idx = 2'h0;
                     if (is_local(s_q.reg_a))
                     begin
                        s_d.rdat = lv;
                        s_d.sh = lv[15:8];
                        s_d.sda_oe = ~lv[15];
                        s_d.st = ispb_pkg::D_TX;
                     end
                     else
                     begin
                        s_d.scl_oe = 1'b1;
                        s_d.scnt = 16'h0000;
                        s_d.rbusy = 1'b1;
                        s_d.spi_act = 1'b1;
                        s_d.spi_sh = {map_reg(s_q.page, s_q.reg_a), 1'b0,
                                      16'h0000};
                        s_d.st = ispb_pkg::D_STR;
                     end
                  end
               end
            end
            ispb_pkg::D_STR:
            begin
               if (s_q.scnt != 16'hFFFF)
               begin
                  s_d.scnt = s_q.scnt + 16'h0001;
               end
               if (!s_q.spi_act && s_q.scnt >= 16'(STRETCH_CYC))
               begin
                  s_d.rbusy = 1'b0;
                  s_d.rdat = s_q.spi_rx;
                  s_d.sh = s_q.spi_rx[15:8];
                  s_d.sda_oe = ~s_q.spi_rx[15];
                  s_d.bc = 4'h0;
                  s_d.st = ispb_pkg::D_TX;
               end
            end
            ispb_pkg::D_TX:
            begin
               // Release a stretch one cycle after SDA is set up
               s_d.scl_oe = 1'b0;
               if (fall)
               begin
                  if (s_q.bc == 4'h7)
                  begin
                     s_d.sda_oe = 1'b0;
                     s_d.st = ispb_pkg::D_TACK;
                  end
                  else
                  begin
                     s_d.bc = s_q.bc + 4'h1;
                     s_d.sh = {s_q.sh[6:0], 1'b0};
                     s_d.sda_oe = ~s_q.sh[6];
                  end
               end
            end
            ispb_pkg::D_TACK:
            begin
               if (rise)
               begin
                  s_d.ack = ~s_q.sda_s[1];
               end
               else if (fall)
               begin
                  s_d.st = ispb_pkg::D_IDLE;
                  if (s_q.ack && s_q.idx == 2'h0)
                  begin
                     s_d.idx = 2'h1;
                     s_d.bc = 4'h0;
                     s_d.sh = s_q.rdat[7:0];
                     s_d.sda_oe = ~s_q.rdat[7];
                     s_d.st = ispb_pkg::D_TX;
                  end
               end
            end
            default:
            begin
               s_d.st = ispb_pkg::D_IDLE;
            end
         endcase
      end
      // Frame launch presets
      if (s_d.spi_act && !s_q.spi_act)
      begin
         s_d.cs_n = 1'b0;
         s_d.spi_cnt = 5'(`ISPB_SPI_BITS - 1);
         s_d.spi_div = SPI_HALF - 8'h01;
         s_d.mosi = s_d.spi_sh[25];
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_core_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         s_q <= '0;
         s_q.st <= ispb_pkg::D_IDLE;
         s_q.scl_s <= 2'h3;
         s_q.sda_s <= 2'h3;
         s_q.scl_l <= 1'b1;
         s_q.sda_l <= 1'b1;
         s_q.cs_n <= 1'b1;
         s_q.page <= `ISPB_PAGE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs
   assign link.dev_scl_o = 1'b0;
   assign link.dev_sda_o = 1'b0;
   assign link.dev_scl_oe = s_q.scl_oe;
   assign link.dev_sda_oe = s_q.sda_oe;
   assign o_spi_sclk = s_q.sclk;
   assign o_spi_cs_n = s_q.cs_n;
   assign o_spi_mosi = s_q.mosi;
   assign o_page = s_q.page;
endmodule // ispb_bridge

/* core/ispb_host.sv */
// I2C master issuing 16-bit register reads and writes
`include "ispb_regs.svh"
module ispb_host #(
   parameter logic [6:0] DEV_ADDR = `ISPB_DEV_ADDR,
   parameter logic [7:0] QUARTER = 8'h7D,
   parameter int WAIT_CYC = `ISPB_WAIT_US * `ISPB_CLK_MHZ
)(
   input wire logic i_core_clk, // System clock
   input wire logic i_sys_rst, // Async reset, high
   ispb_if.host link, // I2C link
   input wire logic [1:0] i_addr, // Command port address
   input wire logic [15:0] i_wdata, // Command port write data
   input wire logic i_wr, // Write strobe
   input wire logic i_rd, // Read strobe
   output logic [15:0] o_rdata // Read data, next cycle
);
   ispb_pkg::ispb_host_t s_q, s_d;

   // Element kind per step
   function automatic ispb_pkg::ispb_kind_t kind(input logic [2:0] st,
                                                 input logic rd);
      if (st == 3'h0 || (rd && st == 3'h3))
         kind = ispb_pkg::K_START;
      else if ((!rd && st == 3'h5) || st == 3'h7)
         kind = ispb_pkg::K_STOP;
      else if (rd && st >= 3'h5)
         kind = ispb_pkg::K_RBYTE;
      else
         kind = ispb_pkg::K_WBYTE;
   endfunction

   // Byte sent at a step
   function automatic logic [7:0] tx_byte(input logic [2:0] st,
                                          input logic rd,
                                          input logic [7:0] ra,
                                          input logic [15:0] wd);
      if (st == 3'h1)
         tx_byte = {DEV_ADDR, 1'b0};
      else if (st == 3'h2)
         tx_byte = ra;
      else if (st == 3'h4)
         tx_byte = rd ? {DEV_ADDR, 1'b1} : wd[7:0];
      else
         tx_byte = wd[15:8];
   endfunction

   // SDA drive at the start of an element
   function automatic logic sda_drv(input ispb_pkg::ispb_kind_t k,
                                    input logic [3:0] bc,
                                    input logic [7:0] sh,
                                    input logic [2:0] st);
      if (k == ispb_pkg::K_STOP)
         sda_drv = 1'b1;
      else if (k == ispb_pkg::K_WBYTE)
         sda_drv = (bc != 4'h8) && !sh[7];
      else if (k == ispb_pkg::K_RBYTE)
         sda_drv = (bc == 4'h8) && (st == 3'h5);
      else
         sda_drv = 1'b0;
   endfunction

   // ==========================================================
   // Next state
   always_comb
   begin
      ispb_pkg::ispb_kind_t k;
      k = kind(s_q.step, s_q.rd);
      s_d = s_q;
      s_d.scl_s = {s_q.scl_s[0], link.scl};
      s_d.sda_s = {s_q.sda_s[0], link.sda};
      // Command port
      if (i_rd)
      begin
         if (i_addr == `ISPB_HSTAT_OFS)
            s_d.rdata = {14'h0000, s_q.nack, s_q.st != ispb_pkg::H_IDLE};
         else if (i_addr == `ISPB_HRDATA_OFS)
            s_d.rdata = s_q.rdat;
         else if (i_addr == `ISPB_HWDATA_OFS)
            s_d.rdata = s_q.wd;
         else
            s_d.rdata = {7'h00, s_q.rd, s_q.reg_a};
      end
      if (i_wr && i_addr == `ISPB_HWDATA_OFS)
         s_d.wd = i_wdata;
      case (s_q.st)
         ispb_pkg::H_IDLE:
         begin
            if (i_wr && i_addr == `ISPB_HCMD_OFS)
            begin
               s_d.rd = i_wdata[`ISPB_HCMD_RD_BIT];
               s_d.reg_a = i_wdata[7:0];
               s_d.nack = 1'b0;
               s_d.step = 3'h0;
               s_d.q = 2'h0;
               s_d.qc = QUARTER;
               s_d.sda_oe = 1'b0;
               s_d.st = ispb_pkg::H_RUN;
            end
         end
         ispb_pkg::H_RUN:
         begin
            if (s_q.qc != 8'h00)
            begin
               s_d.qc = s_q.qc - 8'h01;
            end
            else if (s_q.q != 2'h1 || s_q.scl_s[1])
            begin
               s_d.qc = QUARTER;
               s_d.q = s_q.q + 2'h1;
               if (s_q.q == 2'h0)
               begin
                  s_d.scl_oe = 1'b0;
               end
               else if (s_q.q == 2'h1)
               begin
                  if (k == ispb_pkg::K_START)
                     s_d.sda_oe = 1'b1;
                  else if (k == ispb_pkg::K_STOP)
                     s_d.sda_oe = 1'b0;
                  else if (k == ispb_pkg::K_RBYTE && s_q.bc != 4'h8)
                     s_d.rdat = {s_q.rdat[14:0], s_q.sda_s[1]};
                  else if (k == ispb_pkg::K_WBYTE && s_q.bc == 4'h8)
                     s_d.nack = s_q.sda_s[1];
               end
               else if (s_q.q == 2'h2)
               begin
                  if (k == ispb_pkg::K_STOP)
                  begin
                     s_d.gap = 16'h0000;
                     s_d.st = s_q.rd ? ispb_pkg::H_IDLE : ispb_pkg::H_GAP;
                  end
                  else
                  begin
                     s_d.scl_oe = 1'b1;
                  end
               end
               else
               begin
                  if ((k == ispb_pkg::K_WBYTE || k == ispb_pkg::K_RBYTE) &&
                      s_q.bc != 4'h8)
                  begin
                     s_d.bc = s_q.bc + 4'h1;
                     s_d.sh = {s_q.sh[6:0], 1'b0};
                  end
                  else
                  begin
                     s_d.bc = 4'h0;
                     s_d.step = s_q.step + 3'h1;
                     if (s_q.nack)
                        s_d.step = s_q.rd ? 3'h7 : 3'h5;
                     s_d.sh = tx_byte(s_d.step, s_q.rd, s_q.reg_a, s_q.wd);
                  end
                  s_d.sda_oe = sda_drv(kind(s_d.step, s_q.rd), s_d.bc,
                                       s_d.sh, s_d.step);
               end
            end
         end
         ispb_pkg::H_GAP:
         begin
            s_d.gap = s_q.gap + 16'h0001;
            if (s_q.gap >= 16'(WAIT_CYC))
               s_d.st = ispb_pkg::H_IDLE;
         end
         default:
         begin
            s_d.st = ispb_pkg::H_IDLE;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_core_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         s_q <= '0;
         s_q.st <= ispb_pkg::H_IDLE;
         s_q.scl_s <= 2'h3;
         s_q.sda_s <= 2'h3;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs
   assign link.host_scl_o = 1'b0;
   assign link.host_sda_o = 1'b0;
   assign link.host_scl_oe = s_q.scl_oe;
   assign link.host_sda_oe = s_q.sda_oe;
   assign o_rdata = s_q.rdata;
endmodule // ispb_host

/* shared/ispb_if.sv */
// Open-drain I2C link between host and bridge
interface ispb_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_scl_o;
   logic dev_scl_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // Wired-AND of both ends with pull-up
   assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                 input scl, sda);
   modport dev (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe,
                input scl, sda);
endinterface

/* shared/ispb_pkg.sv */
// Types of the I2C to SPI register bridge and its host
package ispb_pkg;
   // ==========================================================
   // Bridge link states
   typedef enum logic [5:0]
   {
      D_IDLE = 6'h01,
      D_RX = 6'h02,
      D_RACK = 6'h04,
      D_STR = 6'h08,
      D_TX = 6'h10,
      D_TACK = 6'h20
   } ispb_dst_t;
   // ==========================================================
   // Host states and link element kinds
   typedef enum logic [2:0]
   {
      H_IDLE = 3'h1,
      H_RUN = 3'h2,
      H_GAP = 3'h4
   } ispb_hst_t;
   typedef enum logic [1:0]
   {
      K_START = 2'h0,
      K_WBYTE = 2'h1,
      K_RBYTE = 2'h2,
      K_STOP = 2'h3
   } ispb_kind_t;
   // ==========================================================
   // Bridge state
   typedef struct packed
   {
      ispb_dst_t st;
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic [1:0] miso_s;
      logic scl_l;
      logic sda_l;
      logic [7:0] sh;
      logic [3:0] bc;
      logic [1:0] idx;
      logic rd;
      logic ack;
      logic [7:0] reg_a;
      logic [7:0] hi;
      logic [15:0] rdat;
      logic scl_oe;
      logic sda_oe;
      logic page;
      logic wbusy;
      logic rbusy;
      logic [15:0] scnt;
      logic spi_act;
      logic [25:0] spi_sh;
      logic [15:0] spi_rx;
      logic [4:0] spi_cnt;
      logic [7:0] spi_div;
      logic sclk;
      logic cs_n;
      logic mosi;
   } ispb_dev_t;
   // ==========================================================
   // Host state
   typedef struct packed
   {
      ispb_hst_t st;
      logic [2:0] step;
      logic [1:0] q;
      logic [7:0] qc;
      logic [3:0] bc;
      logic [7:0] sh;
      logic rd;
      logic nack;
      logic [7:0] reg_a;
      logic [15:0] wd;
      logic [15:0] rdat;
      logic [15:0] gap;
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_oe;
      logic sda_oe;
      logic [15:0] rdata;
   } ispb_host_t;
endpackage

/* shared/ispb_regs.svh */
// Constants of the I2C to SPI register bridge and its host
// ==========================================================
// Functional notes
// - Bytes: device address, register address, two data
// - Every access moves a full 16-bit value
// - Address LSB 0 writes, 1 reads
// - Host write: S, addr+W, reg, MSB, LSB, P
// - Bridge acknowledges every byte of a write
// - Update after 16 bits, then SPI cycle
// - Host does not wait for SPI write completion, only a fixed gap
// - Host waits 250 us after forwarded write
// - Write-busy set on forwarded write, cleared when done
// - Local registers served at once, always
// - Host read: addr+W, reg, Sr, addr+R
// - Read returns high byte, then low byte
// - Host acks first byte, nacks second, stops
// - Read phase follows write phase without delay
// - Stretch about 200 us before first byte only
// - Sensor register is page times 0x100 plus address
// - 0x97..0x99 handled locally, never forwarded
// - Version: minor in 7:0, major in 15:8
// - Page select is control bit 0, kept
// - Write-busy is status bit 1
`ifndef ISPB_REGS_SVH
`define ISPB_REGS_SVH
// ==========================================================
// Bridge register map
`define ISPB_FW_VER_OFS 8'h97
`define ISPB_CTRL_OFS 8'h98
`define ISPB_STAT_OFS 8'h99
`define ISPB_PAGE_BIT 0
`define ISPB_RBUSY_BIT 0
`define ISPB_WBUSY_BIT 1
`define ISPB_PAGE_RST 1'h0
`define ISPB_PAGE_SIZE 9'h100
`define ISPB_DEV_ADDR 7'h48
// ==========================================================
// Host command port map
`define ISPB_HCMD_OFS 2'h0
`define ISPB_HWDATA_OFS 2'h1
`define ISPB_HSTAT_OFS 2'h2
`define ISPB_HRDATA_OFS 2'h3
`define ISPB_HCMD_RD_BIT 8
`define ISPB_HSTAT_BUSY_BIT 0
`define ISPB_HSTAT_NACK_BIT 1
// ==========================================================
// Timing
`define ISPB_CLK_MHZ 50
`define ISPB_WAIT_US 250
`define ISPB_STRETCH_US 200
`define ISPB_SPI_BITS 26
`endif

/* test/ispb_chk_sva.sv */
// Checker of the link and sensor port of the bridge pair
module ispb_chk #(
   parameter int STRETCH = 50,
   parameter int HALF = 64
)(
   input wire logic i_core_clk, // Clock
   input wire logic i_sys_rst, // Reset
   input wire logic dev_scl_oe, // Bridge holds SCL
   input wire logic dev_sda_oe, // Bridge holds SDA
   input wire logic scl, // SCL level
   input wire logic o_spi_sclk, // SPI clock
   input wire logic o_spi_cs_n, // SPI select
   input wire logic o_spi_mosi, // SPI data
   input wire logic o_page // Page bit
);
   logic [11:0] low_q;
   logic [11:0] hold_q;
   logic [4:0] rise_q;
   logic sclk_q;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // ======================================================
   // Counters of frame length, clock rises and stretch
   always_ff @(posedge i_core_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         low_q <= 12'h000;
         hold_q <= 12'h000;
         rise_q <= 5'h00;
         sclk_q <= 1'h0;
      end
      else
      begin
         sclk_q <= o_spi_sclk;
         low_q <= o_spi_cs_n ? 12'h000 : low_q + 12'h001;
         rise_q <= o_spi_cs_n ? 5'h00 : rise_q + 5'(o_spi_sclk & ~sclk_q);
         hold_q <= dev_scl_oe ? hold_q + 12'h001 : 12'h000;
      end
   end
   // ======================================================
   // Properties
   a_sclk_idle: assert property (o_spi_cs_n |-> !o_spi_sclk)
      else $error("SPI clock moves outside a frame");
   a_frame_bits: assert property ($rose(o_spi_cs_n) |-> rise_q == 5'h1A)
      else $error("SPI frame without 26 clock rises");
   a_frame_len: assert property ($rose(o_spi_cs_n) |->
      low_q >= 51 * HALF && low_q <= 52 * HALF + 16)
      else $error("SPI frame of wrong length");
   a_mosi_on_fall: assert property ($changed(o_spi_mosi) |-> !o_spi_sclk)
      else $error("SPI data changes while clock high");
   a_page_local: assert property ($changed(o_page) |-> o_spi_cs_n)
      else $error("Page change during an SPI frame");
   a_stretch_min: assert property ($fell(dev_scl_oe) |-> hold_q >= STRETCH - 1)
      else $error("Clock stretch too short");
   a_stretch_max: assert property (hold_q <= 52 * HALF + STRETCH + 200)
      else $error("Clock stretch too long");
   a_stretch_spi: assert property ($fell(dev_scl_oe) |-> o_spi_cs_n)
      else $error("Stretch released before SPI read ended");
   a_ack_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("Bridge moves SDA while SCL high");
endmodule // ispb_chk

/* test/tb_i2c_to_spi_register_bridge.sv */
// Self-checking bench of the host and bridge pair
module tb_i2c_to_spi_register_bridge;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] FW = 16'h0A05; // Arbitrary value
   logic i_core_clk, i_sys_rst, i_wr, i_rd, i_spi_miso;
   logic o_spi_sclk, o_spi_cs_n, o_spi_mosi, o_page;
   logic [1:0] i_addr;
   logic [15:0] i_wdata, o_rdata;
   logic [25:0] frame_q;
   int n_fail, comparisons, n_frames, cyc;
   ispb_if lnk();
   ispb_host #(.QUARTER(8'h08), .WAIT_CYC(50)) u_ispb_host (
      .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .link(lnk),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata));
   ispb_bridge #(.FW_VERSION(FW), .STRETCH_CYC(50), .SPI_HALF(8'h40))
   u_ispb_bridge (
      .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .link(lnk),
      .i_spi_miso(i_spi_miso), .o_spi_sclk(o_spi_sclk),
      .o_spi_cs_n(o_spi_cs_n), .o_spi_mosi(o_spi_mosi), .o_page(o_page));
   ispb_chk u_chk (
      .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
      .dev_scl_oe(lnk.dev_scl_oe), .dev_sda_oe(lnk.dev_sda_oe),
      .scl(lnk.scl), .o_spi_sclk(o_spi_sclk), .o_spi_cs_n(o_spi_cs_n),
      .o_spi_mosi(o_spi_mosi), .o_page(o_page));
   // ======================================================
   // Clock, SPI frame capture and hang limit
   initial
   begin
      i_core_clk = 1'h0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   always @(negedge o_spi_cs_n) n_frames++;
   always @(posedge o_spi_sclk) frame_q <= {frame_q[24:0], o_spi_mosi};
   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         n_fail++;
         print_verdict;
      end
   end
   // ======================================================
   // Tasks
   task automatic chk(input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      i_wr <= 1'h1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'h0;
      @(posedge i_core_clk);
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      i_rd <= 1'h1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'h0;
      @(posedge i_core_clk);
      d = o_rdata;
   endtask
   // One link transfer, polled to its end
   task automatic xfer(input logic r, input logic [7:0] ra,
                       input logic [15:0] d, output logic [15:0] q);
      logic [15:0] s;
      int n;
      wr(2'h1, d);
      wr(2'h0, {7'h00, r, ra});
      n = 0;
      do
      begin
         rd(2'h2, s);
         n++;
      end
      while (s[0] !== 1'b0 && n < 5000);
      chk(16'h0000, s);
      rd(2'h3, q);
   endtask
   task automatic print_verdict;
      $display("TB: %0d comparisons, %0d mismatches", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ======================================================
   // Main sequence
   initial
   begin
      logic [15:0] q;
      int n;
      i_sys_rst = 1'h1;
      i_wr = 1'h0;
      i_rd = 1'h0;
      i_addr = 2'h0;
      i_wdata = 16'h0000;
      i_spi_miso = 1'h1;
      repeat (6) @(posedge i_core_clk);
      i_sys_rst <= 1'h0;
      repeat (3) @(posedge i_core_clk);
      // Version register, also after a write attempt
      xfer(1'h1, 8'h97, 16'h0000, q);
      chk(FW, q);
      xfer(1'h0, 8'h97, 16'hFFFF, q);
      xfer(1'h1, 8'h97, 16'h0000, q);
      chk(FW, q);
      // Page select
      xfer(1'h0, 8'h98, 16'h0001, q);
      xfer(1'h1, 8'h98, 16'h0000, q);
      chk(16'h0001, q);
      chk(16'h0001, {15'h0000, o_page});
      chk(16'h0000, 16'(n_frames));
      // Forwarded write on page 1, status while busy
      xfer(1'h0, 8'h09, 16'h0284, q);
      xfer(1'h1, 8'h99, 16'h0000, q);
      chk(16'h0002, q);
      n = 0;
      do
      begin
         xfer(1'h1, 8'h99, 16'h0000, q);
         n++;
      end
      while (q[1] !== 1'b0 && n < 8);
      chk(16'h0000, q);
      chk(16'h0284, frame_q[15:0]);
      chk(16'h0213, 16'(frame_q[25:16]));
      // Forwarded reads at both page ends
      xfer(1'h1, 8'hFF, 16'h0000, q);
      chk(16'hFFFF, q);
      chk(16'h03FE, 16'(frame_q[25:16]));
      xfer(1'h0, 8'h98, 16'h0000, q);
      i_spi_miso <= 1'h0;
      xfer(1'h1, 8'h00, 16'h0000, q);
      chk(16'h0000, q);
      chk(16'h0000, 16'(frame_q[25:16]));
      chk(16'h0003, 16'(n_frames));
      print_verdict;
   end
endmodule // tb_i2c_to_spi_register_bridge
